// ===== tcc_top.sv
// 16-bit timer with two capture/compare registers behind an ahb-lite slave
// assumes a single ahb-lite master, word accesses, capture pins asynchronous to hclk
// Operation
// - count register is read-only and steps by one on each count clock tick.
// - a software read of the count holds off the count tick for a stable value.
// - both mode select bits clear force the count to zero.
// - edge-clear mode zeroes the count on each input A valid edge.
// - match-clear mode zeroes the count when it equals register A.
// - one-shot mode zeroes the count on software trigger or input A valid edge.
// - control bit 0 makes register A capture or compare.
// - register A in compare role raises match A request on equality.
// - input A triggers register A capture on the opposite phase of its valid edge.
// - input B triggers register A capture on the same phase as its valid edge.
// - register A is writable as compare, read-only as capture.
// - reset clears both capture/compare registers and the count.
// - register A at zero matches after the count rolls past all ones.
// - control bit 2 makes register B capture or compare.
// - register B in compare role raises match B request on equality.
// - register B captures the count on the configured valid edge, same phase.
// - register B is writable as compare, read-only as capture.
// - register B at zero matches after the count rolls past all ones.
// - mode select 00 stop, 01 free-run, 10 edge-clear, 11 match-clear.
// - overflow flag sets when the count wraps from all ones to zero.
// - trigger source bit picks input B edge or reversed input A edge.
//
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
`include "tcc_map.svh"

module tcc_top
    import tcc_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // capture pins
    input wire logic capture_input_a,
    input wire logic capture_input_b,
    // match requests
    output logic match_a_irq,
    output logic match_b_irq
);

    // valid edge of an input for its edge code
    function automatic logic valid_edge(input logic [1:0] code, input logic r,
                                        input logic f);
        case (code)
            `TCC_ES_FALL: valid_edge = f;
            `TCC_ES_RISE: valid_edge = r;
            `TCC_ES_BOTH: valid_edge = r | f;
            default: valid_edge = 1'b0;
        endcase
    endfunction

    // opposite phase of the valid edge; both edges gives no capture
    function automatic logic reverse_edge(input logic [1:0] code, input logic r,
                                          input logic f);
        case (code)
            `TCC_ES_FALL: reverse_edge = r;
            `TCC_ES_RISE: reverse_edge = f;
            default: reverse_edge = 1'b0;
        endcase
    endfunction

    // compare hit on a counted step; a register in capture role never matches
    function automatic logic step_hit(input logic step, input logic is_cap,
                                      input tcc_count_t nxt, input tcc_count_t cmp);
        step_hit = step & ~is_cap & (nxt == cmp);
    endfunction

    // write strobe of one register word, raised in its data phase
    function automatic logic wr_hit(input logic pend, input logic [`TCC_AW-1:0] cur,
                                    input logic [`TCC_AW-1:0] addr);
        wr_hit = pend & (cur == addr);
    endfunction

    // registers
    tcc_count_t count_reg;
    tcc_count_t cca_reg;
    tcc_count_t ccb_reg;
    logic [3:0] mode_reg;
    logic [2:0] ccctrl_reg;
    logic [7:0] presc_reg;
    logic os_en_reg;
    logic [31:0] hrdata_reg;
    logic hreadyout_reg;
    logic wr_pend_reg;
    logic [`TCC_AW-1:0] wr_addr_reg;
    logic match_a_reg;
    logic match_b_reg;

    // decoded signals
    tcc_mode_t mode;
    logic access;
    logic rd_acc;
    logic wr_acc;
    logic [`TCC_AW-1:0] a_addr;
    logic count_read;
    logic tick;
    logic run;
    logic a_rise;
    logic a_fall;
    logic b_rise;
    logic b_fall;
    logic [1:0] code_a;
    logic [1:0] code_b;
    logic a_valid;
    logic b_valid;
    logic cap_a_trig;
    logic cap_b_trig;
    logic cca_is_cap;
    logic ccb_is_cap;
    logic os_trig;
    logic edge_clear;
    logic advance;
    logic wrap;
    tcc_count_t count_next;
    logic [31:0] rd_mux;
    logic wr_cca;
    logic wr_ccb;
    logic wr_mode;
    logic wr_ccctrl;
    logic wr_presc;
    logic wr_os;

    // ahb address phase decode; only nonseq/seq transfers are taken
    assign access = hsel & hready & ((htrans == `TCC_HTRANS_NONSEQ) |
                                     (htrans == `TCC_HTRANS_SEQ));
    assign rd_acc = access & ~hwrite;
    assign wr_acc = access & hwrite;
    assign a_addr = haddr[`TCC_AW-1:0];

    // data-phase write strobes
    assign wr_cca = wr_hit(wr_pend_reg, wr_addr_reg, `TCC_ADDR_CCA);
    assign wr_ccb = wr_hit(wr_pend_reg, wr_addr_reg, `TCC_ADDR_CCB);
    assign wr_mode = wr_hit(wr_pend_reg, wr_addr_reg, `TCC_ADDR_MODE);
    assign wr_ccctrl = wr_hit(wr_pend_reg, wr_addr_reg, `TCC_ADDR_CCCTRL);
    assign wr_presc = wr_hit(wr_pend_reg, wr_addr_reg, `TCC_ADDR_PRESC);
    assign wr_os = wr_hit(wr_pend_reg, wr_addr_reg, `TCC_ADDR_ONESHOT);

    // mode decode and role bits
    assign mode = tcc_mode_t'({mode_reg[`TCC_MODE_HI], mode_reg[`TCC_MODE_LO]});
    assign run = (mode != TCC_STOP);
    assign cca_is_cap = ccctrl_reg[`TCC_CC_A_CAP];
    assign ccb_is_cap = ccctrl_reg[`TCC_CC_B_CAP];

    // count clock held off in the cycle a count read is taken
    assign count_read = rd_acc & (a_addr == `TCC_ADDR_COUNT);

    tcc_prescale u_presc (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(run),
        .div_sel(presc_reg[`TCC_PR_DIV_HI:`TCC_PR_DIV_LO]),
        .hold(count_read),
        .tick(tick)
    );

    tcc_edge_sync u_edge_a (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_in(capture_input_a),
        .rise(a_rise),
        .fall(a_fall)
    );

    tcc_edge_sync u_edge_b (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_in(capture_input_b),
        .rise(b_rise),
        .fall(b_fall)
    );

    // edge codes of the two inputs
    assign code_a = presc_reg[`TCC_PR_EA_HI:`TCC_PR_EA_LO];
    assign code_b = presc_reg[`TCC_PR_EB_HI:`TCC_PR_EB_LO];

    // valid edges and capture triggers
    assign a_valid = valid_edge(code_a, a_rise, a_fall);
    assign b_valid = valid_edge(code_b, b_rise, b_fall);
    assign cap_a_trig = ccctrl_reg[`TCC_CC_A_SRC] ?
        reverse_edge(code_a, a_rise, a_fall) :
        b_valid;
    assign cap_b_trig = a_valid;

    // clear sources
    assign os_trig = wr_os & hwdata[`TCC_OS_TRIG];
    assign edge_clear = ((mode == TCC_EDGE_CLR) & a_valid) |
                        (os_en_reg & run & (os_trig | a_valid));
    assign advance = run & tick & ~edge_clear;
    assign wrap = advance & (count_reg == `TCC_CNT_MAX);

    // next count value, stop first, then edge clears, then ticks
    always_comb begin
        if (!run) begin
            count_next = `TCC_CNT_RST;
        end else if (edge_clear) begin
            count_next = `TCC_CNT_RST;
        end else if (advance) begin
            if ((mode == TCC_MATCH_CLR) && (count_reg == cca_reg)) begin
                count_next = `TCC_CNT_RST;
            end else begin
                count_next = count_reg + `TCC_CNT_ONE;
            end
        end else begin
            count_next = count_reg;
        end
    end

    // count register, software never writes it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg <= `TCC_CNT_RST;
        end else begin
            count_reg <= count_next;
        end
    end

    // capture/compare register a
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cca_reg <= `TCC_CC_RST;
        end else if (cca_is_cap) begin
            if (cap_a_trig) begin
                cca_reg <= count_reg;
            end
        end else if (wr_cca) begin
            cca_reg <= hwdata[`TCC_CNT_W-1:0];
        end
    end

    // capture/compare register b
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ccb_reg <= `TCC_CC_RST;
        end else if (ccb_is_cap) begin
            if (cap_b_trig) begin
                ccb_reg <= count_reg;
            end
        end else if (wr_ccb) begin
            ccb_reg <= hwdata[`TCC_CNT_W-1:0];
        end
    end

    // match requests on each counted step that lands on the compare value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            match_a_reg <= 1'b0;
            match_b_reg <= 1'b0;
        end else begin
            match_a_reg <= step_hit(advance, cca_is_cap, count_next, cca_reg);
            match_b_reg <= step_hit(advance, ccb_is_cap, count_next, ccb_reg);
        end
    end

    // mode control; overflow set wins over a software write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_reg <= 4'h0;
        end else begin
            if (wr_mode) begin
                mode_reg <= hwdata[3:0];
            end
            if (wrap) begin
                mode_reg[`TCC_MODE_OVF] <= 1'b1;
            end
        end
    end

    // capture/compare control, prescaler and one-shot enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ccctrl_reg <= 3'h0;
            presc_reg <= 8'h00;
            os_en_reg <= 1'b0;
        end else begin
            if (wr_ccctrl) begin
                ccctrl_reg <= hwdata[2:0];
            end
            if (wr_presc) begin
                presc_reg <= hwdata[7:0];
            end
            if (wr_os) begin
                os_en_reg <= hwdata[`TCC_OS_EN];
            end
        end
    end

    // read multiplexer, unmapped words read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (a_addr)
            `TCC_ADDR_COUNT: rd_mux[`TCC_CNT_W-1:0] = count_reg;
            `TCC_ADDR_CCA: rd_mux[`TCC_CNT_W-1:0] = cca_reg;
            `TCC_ADDR_CCB: rd_mux[`TCC_CNT_W-1:0] = ccb_reg;
            `TCC_ADDR_MODE: rd_mux[3:0] = mode_reg;
            `TCC_ADDR_CCCTRL: rd_mux[2:0] = ccctrl_reg;
            `TCC_ADDR_PRESC: rd_mux[7:0] = presc_reg;
            `TCC_ADDR_ONESHOT: rd_mux[`TCC_OS_EN] = os_en_reg;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // bus slave: read data sampled in the address phase, writes done in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
            hreadyout_reg <= 1'b0;
        end else begin
            hreadyout_reg <= 1'b1;
            if (rd_acc) begin
                hrdata_reg <= rd_mux;
            end
            wr_pend_reg <= wr_acc;
            if (wr_acc) begin
                wr_addr_reg <= a_addr;
            end
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp = `TCC_HRESP_OKAY;
    assign match_a_irq = match_a_reg;
    assign match_b_irq = match_b_reg;

endmodule // tcc_top

// ===== tcc_map.svh
// register map, field positions, reset values and timing constants of the timer
// assumes inclusion by bare name from the package and the design modules
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH

// byte addresses of the register words
`define TCC_ADDR_COUNT 8'h00
`define TCC_ADDR_CCA 8'h04
`define TCC_ADDR_CCB 8'h08
`define TCC_ADDR_MODE 8'h0c
`define TCC_ADDR_CCCTRL 8'h10
`define TCC_ADDR_PRESC 8'h14
`define TCC_ADDR_ONESHOT 8'h18

// widths
`define TCC_CNT_W 16
`define TCC_AW 8

// reset values, count maximum and count step
`define TCC_CNT_RST 16'h0000
`define TCC_CC_RST 16'h0000
`define TCC_CNT_MAX 16'hffff
`define TCC_CNT_ONE 16'h0001

// mode control register fields
`define TCC_MODE_OVF 0
`define TCC_MODE_OUTSEL 1
`define TCC_MODE_LO 2
`define TCC_MODE_HI 3

// capture/compare control register fields
`define TCC_CC_A_CAP 0
`define TCC_CC_A_SRC 1
`define TCC_CC_B_CAP 2

// prescaler mode register fields
`define TCC_PR_DIV_LO 0
`define TCC_PR_DIV_HI 1
`define TCC_PR_EA_LO 4
`define TCC_PR_EA_HI 5
`define TCC_PR_EB_LO 6
`define TCC_PR_EB_HI 7

// one-shot control register fields
`define TCC_OS_TRIG 0
`define TCC_OS_EN 1

// valid edge codes of a capture input
`define TCC_ES_FALL 2'b00
`define TCC_ES_RISE 2'b01
`define TCC_ES_BAD 2'b10
`define TCC_ES_BOTH 2'b11

// ahb encodings
`define TCC_HTRANS_NONSEQ 2'b10
`define TCC_HTRANS_SEQ 2'b11
`define TCC_HRESP_OKAY 1'b0

// prescaler divider width and step
`define TCC_DIV_W 3
`define TCC_DIV_ONE 3'h1

`endif

// ===== tcc_pkg.sv
// types shared by the timer modules
// assumes tcc_map.svh is on the include path
`include "tcc_map.svh"

package tcc_pkg;

    // operating mode from the two mode select bits
    typedef enum logic [1:0] {
        TCC_STOP,
        TCC_FREE,
        TCC_EDGE_CLR,
        TCC_MATCH_CLR
    } tcc_mode_t;

    typedef logic [`TCC_CNT_W-1:0] tcc_count_t;

endpackage

// ===== tcc_edge_sync.sv
// synchroniser and edge detector for one capture input pin
// assumes the pin is asynchronous to hclk; pulses are one hclk wide
module tcc_edge_sync
    import tcc_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // pin
    input wire logic pin_in,
    // edge pulses
    output logic rise,
    output logic fall
);

    logic sync1_reg;
    logic sync2_reg;
    logic last_reg;
    logic [2:0] prime_reg;

    // two-stage synchroniser, then a history stage for edge detection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            last_reg <= 1'b0;
            prime_reg <= 3'b000;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            last_reg <= sync2_reg;
            prime_reg <= {prime_reg[1:0], 1'b1};
        end
    end

    // edges seen on the settled copy only, once the history holds a real pin sample,
    // so a pin resting high gives no false edge after reset
    assign rise = prime_reg[2] & sync2_reg & ~last_reg;
    assign fall = prime_reg[2] & ~sync2_reg & last_reg;

endmodule // tcc_edge_sync

// ===== tcc_prescale.sv
// count clock generator: one-cycle tick every 1, 2, 4 or 8 hclk cycles
// assumes a held tick is delivered as soon as the hold drops; at divide by 1 it merges with the next pulse and is lost
`include "tcc_map.svh"
module tcc_prescale
    import tcc_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control
    input wire logic run,
    input wire logic [1:0] div_sel,
    input wire logic hold,
    // count clock pulse
    output logic tick
);

    logic [`TCC_DIV_W-1:0] div_reg;
    logic pend_reg;
    logic raw;

    // raw pulse when the selected divider bits roll to zero
    always_comb begin
        case (div_sel)
            2'b00: raw = run;
            2'b01: raw = run & div_reg[0];
            2'b10: raw = run & (&div_reg[1:0]);
            default: raw = run & (&div_reg);
        endcase
    end

    // free divider, cleared while stopped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_reg <= '0;
        end else if (!run) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + `TCC_DIV_ONE;
        end
    end

    // a pulse that falls on a hold cycle waits until the hold drops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_reg <= 1'b0;
        end else if (!run) begin
            pend_reg <= 1'b0;
        end else begin
            pend_reg <= hold & (raw | pend_reg);
        end
    end

    assign tick = ~hold & (raw | pend_reg);

endmodule // tcc_prescale

// ===== tcc_top_monitor.sv
// checker of bus answers and match requests at the timer's ports
// assumes it is bound to tcc_top and that the master keeps hready tied to hreadyout
`include "tcc_map.svh"
module tcc_top_monitor (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // capture pins
    input wire logic capture_input_a,
    input wire logic capture_input_b,
    // match requests
    input wire logic match_a_irq,
    input wire logic match_b_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [1:0] mode_q;
    logic rd_go;
    // read address phase taken at this edge
    assign rd_go = hsel && hready && htrans[1] && !hwrite;
    // shadow of the mode select bits, updated when a write data phase ends
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            mode_q <= 2'b00;
        end else if (hready) begin
            wr_pend <= hsel && htrans[1] && hwrite;
            wr_addr <= haddr[7:0];
            if (wr_pend && wr_addr == `TCC_ADDR_MODE) begin
                mode_q <= hwdata[3:2];
            end
        end
    end
    a_ready_high: assert property ($past(hresetn) |-> hreadyout)
        else $error("hreadyout low outside reset");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("hresp not okay");
    a_match_a_pulse: assert property (match_a_irq |=> !match_a_irq)
        else $error("match a request longer than one cycle");
    a_match_b_pulse: assert property (match_b_irq |=> !match_b_irq)
        else $error("match b request longer than one cycle");
    a_rdata_hold: assert property (!$past(rd_go) |-> $stable(hrdata))
        else $error("read data changed without a read");
    a_upper_zero: assert property (rd_go |=> hrdata[31:16] == 16'h0000)
        else $error("upper read data bits not zero");
    a_unmapped_zero: assert property (rd_go && haddr[7:0] > `TCC_ADDR_ONESHOT |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_stop_count_zero: assert property (rd_go && haddr[7:0] == `TCC_ADDR_COUNT
        && mode_q == 2'b00 && $past(mode_q, 2) == 2'b00 |=> hrdata == 32'h0)
        else $error("count not zero while stopped");
    a_stop_no_match: assert property (mode_q == 2'b00 && $past(mode_q, 2) == 2'b00
        |-> !match_a_irq && !match_b_irq)
        else $error("match request while stopped");
endmodule // tcc_top_monitor

bind tcc_top tcc_top_monitor tcc_top_monitor_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .capture_input_a(capture_input_a), .capture_input_b(capture_input_b),
    .match_a_irq(match_a_irq), .match_b_irq(match_b_irq));

// ===== tcc_pin_model.sv
// model of the two capture/trigger pins outside the timer
// assumes the bench calls drive right after a rising edge of hclk
module tcc_pin_model (
    // clock
    input wire logic hclk,
    // pins
    output logic pin_a,
    output logic pin_b
);
    timeunit 1ns;
    timeprecision 1ps;
    // pins start at rest, a low and b high
    initial begin
        pin_a = 1'b0;
        pin_b = 1'b1;
    end
    // moves one pin after a rising edge and holds it until told otherwise
    task automatic drive(input logic sel, input logic lvl);
        @(posedge hclk);
        if (sel) begin
            pin_b <= lvl;
        end else begin
            pin_a <= lvl;
        end
    endtask
endmodule // tcc_pin_model

// ===== tcc_top_tb.sv
// self-checking bench: register access, matches, clears and captures of the timer
// assumes tcc_top, tcc_pin_model and the checker are compiled before it
`include "tcc_map.svh"
module tcc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic pin_a;
    logic pin_b;
    logic match_a_irq;
    logic match_b_irq;
    logic [31:0] prev_a;
    logic [31:0] prev_b;
    logic [31:0] rv;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n;
    tcc_top tcc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .capture_input_a(pin_a),
        .capture_input_b(pin_b), .match_a_irq(match_a_irq), .match_b_irq(match_b_irq));
    tcc_pin_model tcc_pin_model_i (.hclk(hclk), .pin_a(pin_a), .pin_b(pin_b));
    // 40 mhz bus clock
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    // hang guard, well above the roll-over wait
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        if (err_total == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wait_rdy();
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    // one single word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        haddr <= {24'h000000, a};
        htrans <= `TCC_HTRANS_NONSEQ;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rv);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, rv);
        chk(nm, exp, rv);
    endtask
    task automatic rd_in(input string nm, input logic [7:0] a, input logic [31:0] lo,
            input logic [31:0] hi);
        bus(1'b0, a, 32'h0, rv);
        chk(nm, 32'h1, {31'h0, rv >= lo && rv <= hi});
    endtask
    // counts falling edges until a match request is seen
    task automatic wait_irq(input logic b, input int lim, output int k);
        k = 0;
        do begin
            @(negedge hclk);
            k++;
        end while ((b ? match_b_irq : match_a_irq) !== 1'b1 && k < lim);
    endtask
    // moves a pin; each register either takes a count between two reads or keeps its value
    task automatic cap_step(input logic sel, input logic lvl, input logic ea, input logic eb);
        logic [31:0] c0;
        logic [31:0] c1;
        logic [31:0] va;
        logic [31:0] vb;
        bus(1'b0, `TCC_ADDR_COUNT, 32'h0, c0);
        tcc_pin_model_i.drive(sel, lvl);
        repeat (8) @(posedge hclk);
        bus(1'b0, `TCC_ADDR_COUNT, 32'h0, c1);
        bus(1'b0, `TCC_ADDR_CCA, 32'h0, va);
        bus(1'b0, `TCC_ADDR_CCB, 32'h0, vb);
        chk("cca", 32'h1, {31'h0, ea ? (va >= c0 && va <= c1) : (va === prev_a)});
        chk("ccb", 32'h1, {31'h0, eb ? (vb >= c0 && vb <= c1) : (vb === prev_b)});
        prev_a = va;
        prev_b = vb;
    endtask
    // main sequence
    initial begin
        hresetn <= 1'b0;
        hsel <= 1'b1;
        haddr <= 32'h0;
        htrans <= 2'b00;
        hwrite <= 1'b0;
        hsize <= 3'b010;
        hwdata <= 32'h0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        wait_rdy();
        rd_chk("count", `TCC_ADDR_COUNT, 32'h0);
        rd_chk("cca", `TCC_ADDR_CCA, 32'h0);
        rd_chk("ccb", `TCC_ADDR_CCB, 32'h0);
        rd_chk("hole", 8'h1c, 32'h0);
        wr(`TCC_ADDR_COUNT, 32'h1234);
        rd_chk("count", `TCC_ADDR_COUNT, 32'h0);
        wr(`TCC_ADDR_CCA, 32'h0040);
        wr(`TCC_ADDR_CCB, 32'h0080);
        rd_chk("cca", `TCC_ADDR_CCA, 32'h40);
        rd_chk("ccb", `TCC_ADDR_CCB, 32'h80);
        // free run: match b follows match a by the compare distance
        wr(`TCC_ADDR_MODE, 32'h4);
        wait_irq(1'b0, 300, n);
        wait_irq(1'b1, 300, n);
        chk("a_to_b", 32'd64, n);
        @(posedge hclk);
        // match clear: period is the compare value plus one tick
        wr(`TCC_ADDR_MODE, 32'h0);
        wr(`TCC_ADDR_CCA, 32'h0010);
        wr(`TCC_ADDR_MODE, 32'hc);
        wait_irq(1'b0, 300, n);
        wait_irq(1'b0, 300, n);
        chk("clr_period", 32'd17, n);
        @(posedge hclk);
        rd_in("count", `TCC_ADDR_COUNT, 32'h0, 32'h10);
        // one-shot trigger zeroes a running count and reads back as zero
        wr(`TCC_ADDR_MODE, 32'h4);
        wr(`TCC_ADDR_ONESHOT, 32'h2);
        repeat (100) @(posedge hclk);
        wr(`TCC_ADDR_ONESHOT, 32'h3);
        rd_in("count", `TCC_ADDR_COUNT, 32'h0, 32'h8);
        rd_chk("oneshot", `TCC_ADDR_ONESHOT, 32'h2);
        wr(`TCC_ADDR_ONESHOT, 32'h0);
        // edge clear: a rising edge on input a zeroes the count
        wr(`TCC_ADDR_PRESC, 32'h10);
        wr(`TCC_ADDR_MODE, 32'h8);
        repeat (100) @(posedge hclk);
        wr(`TCC_ADDR_COUNT, 32'h0);
        rd_in("count", `TCC_ADDR_COUNT, 32'd90, 32'hffff);
        bus(1'b0, `TCC_ADDR_COUNT, 32'h0, prev_a);
        bus(1'b0, `TCC_ADDR_COUNT, 32'h0, rv);
        chk("hold_step", 32'h1, rv - prev_a);
        tcc_pin_model_i.drive(1'b0, 1'b1);
        repeat (8) @(posedge hclk);
        rd_in("count", `TCC_ADDR_COUNT, 32'h0, 32'd12);
        tcc_pin_model_i.drive(1'b0, 1'b0);
        // capture roles, trigger sources and edge codes
        wr(`TCC_ADDR_MODE, 32'h0);
        wr(`TCC_ADDR_CCCTRL, 32'h5);
        wr(`TCC_ADDR_MODE, 32'h4);
        bus(1'b0, `TCC_ADDR_CCA, 32'h0, prev_a);
        bus(1'b0, `TCC_ADDR_CCB, 32'h0, prev_b);
        cap_step(1'b1, 1'b0, 1'b1, 1'b0);
        cap_step(1'b0, 1'b1, 1'b0, 1'b1);
        wr(`TCC_ADDR_CCA, 32'h5555);
        wr(`TCC_ADDR_CCB, 32'haaaa);
        rd_chk("cca", `TCC_ADDR_CCA, prev_a);
        rd_chk("ccb", `TCC_ADDR_CCB, prev_b);
        wr(`TCC_ADDR_CCCTRL, 32'h7);
        cap_step(1'b0, 1'b0, 1'b1, 1'b0);
        cap_step(1'b0, 1'b1, 1'b0, 1'b1);
        wr(`TCC_ADDR_PRESC, 32'h30);
        cap_step(1'b0, 1'b0, 1'b0, 1'b1);
        wr(`TCC_ADDR_PRESC, 32'h20);
        cap_step(1'b0, 1'b1, 1'b0, 1'b0);
        // zero compare values match only after the count rolls over
        wr(`TCC_ADDR_MODE, 32'h0);
        wr(`TCC_ADDR_CCCTRL, 32'h0);
        wr(`TCC_ADDR_PRESC, 32'h0);
        wr(`TCC_ADDR_CCA, 32'h0);
        wr(`TCC_ADDR_CCB, 32'h0);
        wr(`TCC_ADDR_MODE, 32'h4);
        wait_irq(1'b0, 70000, n);
        chk("b_with_a", 32'h1, {31'h0, match_b_irq});
        chk("roll", 32'h1, {31'h0, n >= 65530 && n <= 65545});
        @(posedge hclk);
        rd_chk("mode", `TCC_ADDR_MODE, 32'h5);
        wrap_up();
    end
endmodule // tcc_top_tb
